// file: rtl/hpt_host_port.sv
// Top of the host port: host pin side, core Avalon slave, memory master
module hpt_host_port
  import hpt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] host_data_bus_i,
  output logic [15:0] host_data_bus_o,
  output logic host_data_bus_oe_n_o,
  input wire logic [1:0] access_select_i,
  input wire logic halfword_select_i,
  input wire logic [1:0] write_byte_enables_n_i,
  input wire logic read_write_select_i,
  input wire logic data_strobe_one_n_i,
  input wire logic data_strobe_two_n_i,
  input wire logic chip_select_n_i,
  output logic host_ready_o,
  output logic host_interrupt_n_o,
  output logic core_interrupt_o,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  output logic [3:0] mem_be_o,
  output logic mem_we_o,
  output logic mem_req_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i
);
  //----------------------------------------------------------------------
  // Input synchronisers
  //----------------------------------------------------------------------
  // Raw pins only; strobe decoding waits until after the second flop
  localparam int SYW = 25;
  logic [SYW-1:0] sy_raw, sy_a, sy_b;
  assign sy_raw = {host_data_bus_i, access_select_i, halfword_select_i,
                   write_byte_enables_n_i, read_write_select_i,
                   data_strobe_one_n_i, data_strobe_two_n_i,
                   chip_select_n_i};
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sy_a <= '1;
      sy_b <= '1;
    end else begin
      sy_a <= sy_raw; // [RULE21]
      sy_b <= sy_a;
    end
  end
  logic [15:0] s_data;
  logic [1:0] s_sel;
  logic s_hw, s_rnw, s_strobe_n, s_ds1_n, s_ds2_n, s_cs_n;
  logic [1:0] s_be_n;
  assign {s_data, s_sel, s_hw, s_be_n, s_rnw, s_ds1_n, s_ds2_n,
          s_cs_n} = sy_b;
  // Strobe counts only while exactly one data strobe is low
  assign s_strobe_n = (s_ds1_n ~^ s_ds2_n) | s_cs_n; // [RULE18]
  //----------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------
  typedef struct packed {
    hpt_state_e state;
    logic [31:0] ptr;
    logic [15:0] ctl;
    logic [31:0] wbuf; // One word held, no queue [RULE15]
    logic [3:0] wbe;
    logic [31:0] rbuf;
    logic pre_valid;
    logic [15:0] dout;
    logic drive;
    logic [31:0] blk_base;
    logic [31:0] blk_mask;
    logic [31:0] avs_rd;
    logic avs_ack;
    logic req;
    logic we;
    logic [31:0] maddr;
    logic inc_after;
  } hpt_top_s;
  hpt_top_s st_reg, st_next;
  hpt_mem_if mem_bus ();
  hpt_aux_channel u_aux (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .mem(mem_bus.chan),
    .blk_base_i(st_reg.blk_base),
    .blk_mask_i(st_reg.blk_mask),
    .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o),
    .mem_be_o(mem_be_o),
    .mem_we_o(mem_we_o),
    .mem_req_o(mem_req_o),
    .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i)
  );
  assign mem_bus.req = st_reg.req;
  assign mem_bus.we = st_reg.we;
  assign mem_bus.addr = st_reg.maddr;
  assign mem_bus.wdata = st_reg.wbuf;
  assign mem_bus.be = st_reg.wbe;
  //----------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------
  logic upper;
  logic [15:0] hsel;
  logic [1:0] bsel;
  logic av_hit;
  always_comb begin
    st_next = st_reg;
    st_next.avs_ack = 1'b0;
    // Upper half goes first when the order bit is set
    upper = st_reg.ctl[HPT_CTL_ORDER] ? !s_hw : s_hw; // [RULE6]
    bsel = ~s_be_n; // [RULE4]
    hsel = 16'h0000;
    av_hit = (avs_read || avs_write) && !st_reg.avs_ack;
    unique case (st_reg.state)
      HPT_IDLE: begin
        if (!s_strobe_n) begin
          st_next.state = HPT_WAIT_REL; // [RULE21]
          unique case (s_sel) // [RULE7] [RULE8]
            HPT_SEL_CTRL: begin
              if (s_rnw) begin
                st_next.dout = st_reg.ctl; // [RULE1]
              end else begin
                st_next.ctl[HPT_CTL_ORDER] = s_data[HPT_CTL_ORDER];
                if (s_data[HPT_CTL_CORE_INT]) begin
                  st_next.ctl[HPT_CTL_CORE_INT] = 1'b1; // [RULE9]
                end
                if (s_data[HPT_CTL_HOST_INT]) begin
                  st_next.ctl[HPT_CTL_HOST_INT] = 1'b0;
                end
              end
            end
            HPT_SEL_PTR: begin
              if (s_rnw) begin
                st_next.dout = upper ? st_reg.ptr[31:16]
                                     : st_reg.ptr[15:0];
              end else if (upper) begin
                st_next.ptr[31:16] = s_data; // [RULE3] [RULE16]
                st_next.pre_valid = 1'b0;
              end else begin
                st_next.ptr[15:0] = s_data;
                st_next.pre_valid = 1'b0;
              end
            end
            default: begin
              if (s_rnw) begin
                hsel = upper ? st_reg.rbuf[31:16] : st_reg.rbuf[15:0];
                st_next.dout = hsel;
                if (!s_hw && !st_reg.pre_valid) begin
                  st_next.req = 1'b1; // [RULE19]
                  st_next.we = 1'b0;
                  st_next.maddr = st_reg.ptr;
                  st_next.state = HPT_MEM_RD;
                end else if (s_hw && s_sel == HPT_SEL_INC) begin
                  st_next.ptr = st_reg.ptr + HPT_WORD_STEP; // [RULE10]
                  st_next.req = 1'b1; // [RULE11]
                  st_next.we = 1'b0;
                  st_next.maddr = st_reg.ptr + HPT_WORD_STEP;
                  st_next.state = HPT_PREFETCH;
                end else if (s_hw) begin
                  st_next.pre_valid = 1'b0;
                end
              end else begin
                if (upper) begin
                  st_next.wbuf[31:16] = s_data; // [RULE3]
                  st_next.wbe[3:2] = bsel;
                end else begin
                  st_next.wbuf[15:0] = s_data;
                  st_next.wbe[1:0] = bsel;
                end
                if (!s_hw) begin
                  st_next.wbe = upper ? {bsel, 2'h0} : {2'h0, bsel};
                end
                // Second half commits; a lone first half waits for it
                if (s_hw) begin
                  st_next.req = 1'b1; // [RULE17]
                  st_next.we = 1'b1;
                  st_next.maddr = st_reg.ptr;
                  st_next.inc_after = (s_sel == HPT_SEL_INC);
                  st_next.pre_valid = 1'b0;
                  st_next.state = HPT_MEM_WR;
                end
              end
            end
          endcase
          // A read miss drives only once the memory word is back
          st_next.drive = s_rnw && (st_next.state != HPT_MEM_RD); // [RULE20]
        end
      end
      HPT_WAIT_REL: begin
        if (s_strobe_n) begin
          st_next.state = HPT_IDLE;
          st_next.drive = 1'b0; // [RULE20]
        end
      end
      HPT_MEM_WR, HPT_MEM_RD, HPT_PREFETCH: begin
        if (mem_bus.done) begin
          st_next.req = 1'b0;
          if (st_reg.state != HPT_MEM_WR) begin
            st_next.rbuf = mem_bus.rdata;
            st_next.pre_valid = (st_reg.state == HPT_PREFETCH);
          end
          if (st_reg.state == HPT_MEM_RD) begin
            hsel = upper ? mem_bus.rdata[31:16] : mem_bus.rdata[15:0];
            st_next.dout = hsel;
          end
          if (st_reg.inc_after) begin
            st_next.ptr = st_reg.ptr + HPT_WORD_STEP; // [RULE10]
            st_next.inc_after = 1'b0;
          end
          st_next.state = s_strobe_n ? HPT_IDLE : HPT_WAIT_REL;
          st_next.drive = !s_strobe_n
                          && (st_reg.drive || st_reg.state == HPT_MEM_RD);
        end else if (s_strobe_n) begin
          st_next.drive = 1'b0;
        end
      end
      default: st_next.state = HPT_IDLE;
    endcase
    st_next.ctl[HPT_CTL_READY] = (st_next.state == HPT_IDLE)
                                 || (st_next.state == HPT_WAIT_REL);
    // Core-side Avalon slave; answers in one wait cycle
    if (av_hit) begin
      st_next.avs_ack = 1'b1;
      st_next.avs_rd = 32'h0000_0000;
      unique case (avs_address)
        HPT_AV_CTRL: begin
          st_next.avs_rd = {16'h0000, st_reg.ctl}; // [RULE1] [RULE13]
          if (avs_write && avs_byteenable[0]) begin
            st_next.ctl[HPT_CTL_ORDER] = avs_writedata[HPT_CTL_ORDER];
            if (avs_writedata[HPT_CTL_CORE_INT] &&
                !(!s_strobe_n && st_reg.state == HPT_IDLE
                  && s_sel == HPT_SEL_CTRL && !s_rnw
                  && s_data[HPT_CTL_CORE_INT])) begin
              st_next.ctl[HPT_CTL_CORE_INT] = 1'b0;
            end
            if (avs_writedata[HPT_CTL_HOST_INT]) begin
              st_next.ctl[HPT_CTL_HOST_INT] = 1'b1; // [RULE9]
            end
          end
        end
        HPT_AV_BLK0_BASE: begin
          st_next.avs_rd = st_reg.blk_base;
          if (avs_write) begin
            st_next.blk_base = avs_writedata; // [RULE2]
          end
        end
        HPT_AV_BLK0_MASK: begin
          st_next.avs_rd = st_reg.blk_mask;
          if (avs_write) begin
            st_next.blk_mask = avs_writedata;
          end
        end
        HPT_AV_PTR: st_next.avs_rd = st_reg.ptr;
        default: st_next.avs_rd = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.ctl <= HPT_CTL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end
  //----------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------
  // Ready drops for each data word that starts a memory access, until the memory side finishes
  assign host_ready_o = st_reg.ctl[HPT_CTL_READY]; // [RULE12] [RULE14]
  assign host_interrupt_n_o = !st_reg.ctl[HPT_CTL_HOST_INT];
  assign core_interrupt_o = st_reg.ctl[HPT_CTL_CORE_INT];
  assign host_data_bus_o = st_reg.dout;
  assign host_data_bus_oe_n_o = !st_reg.drive; // [RULE20]
  assign avs_readdata = st_reg.avs_rd;
  assign avs_waitrequest = (avs_read || avs_write) && !st_reg.avs_ack;
endmodule : hpt_host_port

// file: rtl/hpt_pkg.sv
// Package with constants and types for the host port block
//------------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------------
// Overview of operation
// RULE1 - Host reaches pointer, data, control; core reaches control
// RULE2 - Blocked regions refused, other addresses forwarded
// RULE3 - Two halfwords merge into one word
// RULE4 - Byte enables gate data writes only
// RULE5 - Host sends first then second halfword
// RULE6 - Control bit picks which halfword is upper
// RULE7 - Two select inputs choose the register
// RULE8 - 00 control, 01 pointer, 10 increment, 11 fixed
// RULE9 - Interrupts both ways through control bits
// RULE10 - Autoincrement advances pointer one word
// RULE11 - Autoincrement read prefetches next word
// RULE12 - Ready held low while access unfinished
// RULE13 - Readiness mirrored in a control bit
// RULE14 - Unbuffered variant: not-ready after each word; a fixed read served from the prefetched word leaves ready high
// RULE15 - Buffered variants are not built here
// RULE16 - Single pointer, host only, unbuffered variant
// RULE17 - Single halfword access only with byte enables
// RULE18 - Strobes decoded from two strobes and direction; the code decodes them from the two strobes and chip select
// RULE19 - Data transfers go through auxiliary memory channel
// RULE20 - Data bus released unless answering a read
// RULE21 - Host inputs synchronised, one access per strobe
package hpt_pkg;
  localparam logic [1:0] HPT_SEL_CTRL = 2'h0;
  localparam logic [1:0] HPT_SEL_PTR = 2'h1;
  localparam logic [1:0] HPT_SEL_INC = 2'h2;
  localparam logic [1:0] HPT_SEL_FIX = 2'h3;
  localparam logic [31:0] HPT_WORD_STEP = 32'h0000_0004;
  // Control register bit positions, layout of this design
  localparam int HPT_CTL_ORDER = 0;
  localparam int HPT_CTL_CORE_INT = 1;
  localparam int HPT_CTL_HOST_INT = 2;
  localparam int HPT_CTL_READY = 3;
  localparam logic [15:0] HPT_CTL_RESET = 16'h0008;
  // Avalon register offsets (byte addresses)
  localparam logic [3:0] HPT_AV_CTRL = 4'h0;
  localparam logic [3:0] HPT_AV_BLK0_BASE = 4'h4;
  localparam logic [3:0] HPT_AV_BLK0_MASK = 4'h8;
  localparam logic [3:0] HPT_AV_PTR = 4'hC;
  typedef enum logic [2:0] {
    HPT_IDLE, HPT_WAIT_REL, HPT_MEM_WR, HPT_MEM_RD, HPT_PREFETCH
  } hpt_state_e;
endpackage : hpt_pkg

// file: rtl/hpt_mem_if.sv
// Interface carrying the auxiliary memory channel requests
interface hpt_mem_if;
  logic req;
  logic we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic done;
  logic [31:0] rdata;
  logic refused;
  modport port (output req, we, addr, wdata, be,
                input done, rdata, refused);
  modport chan (input req, we, addr, wdata, be,
                output done, rdata, refused);
endinterface : hpt_mem_if

// file: rtl/hpt_aux_channel.sv
// Auxiliary channel: guards blocked regions, drives the memory master
module hpt_aux_channel
  import hpt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  hpt_mem_if.chan mem,
  input wire logic [31:0] blk_base_i,
  input wire logic [31:0] blk_mask_i,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  output logic [3:0] mem_be_o,
  output logic mem_we_o,
  output logic mem_req_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i
);
  typedef struct packed {
    logic busy;
    logic done;
    logic refused;
    logic [31:0] rdata;
  } hpt_aux_s;
  hpt_aux_s st_reg, st_next;
  logic blocked;
  assign blocked = ((mem.addr & blk_mask_i) == blk_base_i)
                   && (blk_mask_i != 32'h0000_0000);
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.refused = 1'b0;
    if (!st_reg.busy && mem.req && !st_reg.done) begin
      if (blocked) begin
        st_next.done = 1'b1; // [RULE2]
        st_next.refused = 1'b1;
        st_next.rdata = 32'h0000_0000;
      end else begin
        st_next.busy = 1'b1; // [RULE19]
      end
    end else if (st_reg.busy && mem_ack_i) begin
      st_next.busy = 1'b0;
      st_next.done = 1'b1;
      st_next.rdata = mem_rdata_i;
    end
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign mem_req_o = st_reg.busy;
  assign mem_we_o = mem.we;
  assign mem_addr_o = mem.addr;
  assign mem_wdata_o = mem.wdata;
  assign mem_be_o = mem.be;
  assign mem.done = st_reg.done;
  assign mem.rdata = st_reg.rdata;
  assign mem.refused = st_reg.refused;
endmodule : hpt_aux_channel

// file: testbench/hpt_host_port_props.sv
// Checker of port relations for the host port top
module hpt_host_port_props
  import hpt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] host_data_bus_o,
  input wire logic host_data_bus_oe_n_o,
  input wire logic read_write_select_i,
  input wire logic chip_select_n_i,
  input wire logic host_ready_o,
  input wire logic host_interrupt_n_o,
  input wire logic core_interrupt_o,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic [31:0] mem_addr_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic mem_ack_i
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  logic ctl_wr;
  // The slave takes a write at the edge that still shows waitrequest
  assign ctl_wr = avs_write && avs_waitrequest && avs_address == HPT_AV_CTRL;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_avs_one_wait: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("slow answer");
  a_mem_not_ready: assert property (mem_req_o |-> !host_ready_o)
    else $error("ready high during memory access");
  a_mem_req_hold: assert property (mem_req_o && !mem_ack_i |=>
    mem_req_o && $stable(mem_addr_o)) else $error("memory request dropped");
  a_bus_idle_off: assert property (chip_select_n_i [*4] |->
    host_data_bus_oe_n_o) else $error("bus driven while idle");
  a_bus_read_only: assert property ($fell(host_data_bus_oe_n_o) |->
    $past(read_write_select_i, 1) && $past(read_write_select_i, 2))
    else $error("bus driven on a write");
  a_bus_data_hold: assert property (!host_data_bus_oe_n_o &&
    $past(!host_data_bus_oe_n_o) |-> $stable(host_data_bus_o))
    else $error("read data moved while driven");
  a_core_int_hold: assert property (core_interrupt_o &&
    !(ctl_wr && avs_writedata[HPT_CTL_CORE_INT]) |=> core_interrupt_o)
    else $error("core interrupt lost");
  a_host_int_set: assert property ($fell(host_interrupt_n_o) |->
    $past(ctl_wr && avs_writedata[HPT_CTL_HOST_INT]))
    else $error("host interrupt without request");
  c_mem_write: cover property (mem_req_o && mem_we_o && mem_ack_i);
  c_mem_read: cover property (mem_req_o && !mem_we_o && mem_ack_i);
  c_host_int: cover property ($fell(host_interrupt_n_o));
endmodule : hpt_host_port_props

bind hpt_host_port hpt_host_port_props u_props (.ref_clk_i, .rst_i,
  .host_data_bus_o, .host_data_bus_oe_n_o, .read_write_select_i,
  .chip_select_n_i, .host_ready_o, .host_interrupt_n_o, .core_interrupt_o,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest,
  .mem_addr_o, .mem_req_o, .mem_we_o, .mem_ack_i);

// file: testbench/hpt_host_model.sv
// Host processor model driving the parallel host pins
module hpt_host_model (
  input wire logic clk_i,
  input wire logic [15:0] drv_data_i,
  input wire logic oe_n_i,
  input wire logic ready_i,
  output logic [15:0] data_o,
  output logic [1:0] sel_o,
  output logic hw_o,
  output logic [1:0] ben_n_o,
  output logic rw_o,
  output logic ds1_n_o,
  output logic ds2_n_o,
  output logic cs_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] dat;
  // Wire level: our value, or the device's while it drives
  assign data_o = oe_n_i ? dat : drv_data_i;
  initial begin
    dat = 16'h0000;
    {sel_o, hw_o, ben_n_o, rw_o, ds1_n_o, ds2_n_o, cs_n_o} = 9'h1FF;
  end
  // One halfword access; reads strobe on the second strobe pin
  task automatic acc(input logic [1:0] s, input logic w, input logic h,
                     input logic [1:0] b, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    sel_o <= s;
    rw_o <= w;
    hw_o <= h;
    ben_n_o <= b;
    dat <= d;
    @(posedge clk_i);
    if (w) begin
      ds2_n_o <= 1'b0;
    end else begin
      ds1_n_o <= 1'b0;
    end
    repeat (6) @(posedge clk_i);
    while (w && oe_n_i) @(posedge clk_i);
    q = drv_data_i;
    ds1_n_o <= 1'b1;
    ds2_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    cs_n_o <= 1'b1;
    dat <= ~dat;
    while (!ready_i) @(posedge clk_i);
  endtask : acc
endmodule : hpt_host_model

// file: testbench/tb_hpt_host_port.sv
// Self-checking bench for the host port top
module tb_hpt_host_port;
  import hpt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i, rst_i, mem_ack_i, oe_n, rdy, host_interrupt_n_n, cint, rw, hw;
  logic ds1_n, ds2_n, cs_n, avs_read, avs_write, avs_waitrequest;
  logic mem_we_o, mem_req_o, l_we;
  logic [15:0] hd_i, hd_o, r;
  logic [1:0] sel, ben_n;
  logic [3:0] avs_address, mem_be_o, l_be;
  logic [31:0] avs_writedata, avs_readdata, mem_addr_o, mem_wdata_o, q;
  logic [31:0] l_addr, l_wd;
  int n_fail, check_count, n_mem, dly, cyc, k;

  hpt_host_port u_hpt_host_port (.ref_clk_i, .rst_i,
    .host_data_bus_i(hd_i), .host_data_bus_o(hd_o),
    .host_data_bus_oe_n_o(oe_n), .access_select_i(sel),
    .halfword_select_i(hw), .write_byte_enables_n_i(ben_n),
    .read_write_select_i(rw), .data_strobe_one_n_i(ds1_n),
    .data_strobe_two_n_i(ds2_n), .chip_select_n_i(cs_n),
    .host_ready_o(rdy), .host_interrupt_n_o(host_interrupt_n_n),
    .core_interrupt_o(cint), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
    .mem_addr_o, .mem_wdata_o, .mem_be_o, .mem_we_o, .mem_req_o, .mem_ack_i,
    .mem_rdata_i(mem_ack_i ? {16'h1234, mem_addr_o[15:0]} : ~mem_addr_o));
  hpt_host_model u_hpt_host_model (.clk_i(ref_clk_i), .drv_data_i(hd_o),
    .oe_n_i(oe_n), .ready_i(rdy), .data_o(hd_i), .sel_o(sel), .hw_o(hw),
    .ben_n_o(ben_n), .rw_o(rw), .ds1_n_o(ds1_n), .ds2_n_o(ds2_n),
    .cs_n_o(cs_n));

  // ----------------------------------------
  // Clock, memory responder, timeout
  // ----------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // Answers after three cycles so ready is seen low in between
  always @(posedge ref_clk_i) begin
    mem_ack_i <= 1'b0;
    cyc <= cyc + 1;
    if (mem_req_o && !mem_ack_i) begin
      dly <= (dly == 2) ? 0 : dly + 1;
      if (dly == 2) begin
        mem_ack_i <= 1'b1;
        n_mem <= n_mem + 1;
        {l_addr, l_wd, l_be, l_we} <= {mem_addr_o, mem_wdata_o, mem_be_o,
                                       mem_we_o};
      end
    end
    if (cyc == 5000) begin
      $display("[ERR] run time expected below %0d seen %0d", 5000, cyc);
      n_fail++;
      summarize();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge ref_clk_i); while (avs_waitrequest);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk_i);
  endtask : av
  task automatic avchk(input logic [3:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0000_0000);
    chk("avalon read", e, q);
  endtask : avchk
  task automatic wr2(input logic [1:0] s, b, input logic [15:0] d0, d1);
    u_hpt_host_model.acc(s, 1'b0, 1'b0, b, d0, r);
    u_hpt_host_model.acc(s, 1'b0, 1'b1, b, d1, r);
  endtask : wr2
  task automatic rd2(input logic [1:0] s, input logic [15:0] e0, e1);
    u_hpt_host_model.acc(s, 1'b1, 1'b0, 2'h0, 16'h0000, r);
    chk("first half", {16'h0000, e0}, {16'h0000, r});
    u_hpt_host_model.acc(s, 1'b1, 1'b1, 2'h0, 16'h0000, r);
    chk("second half", {16'h0000, e1}, {16'h0000, r});
  endtask : rd2
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst_i, avs_read, avs_write, avs_address, avs_writedata} = 39'h40_0000_0000;
    {mem_ack_i, n_mem, dly, cyc} = 0;
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    chk("pins", 32'h7, {29'h0, rdy, host_interrupt_n_n, oe_n});
    avchk(HPT_AV_CTRL, 32'h0000_0008);
    avchk(4'h2, 32'h0000_0000);
    $display("test reset done");
    wr2(HPT_SEL_PTR, 2'h0, 16'h0100, 16'h0000);
    avchk(HPT_AV_PTR, 32'h0000_0100);
    wr2(HPT_SEL_INC, 2'h0, 16'hBEEF, 16'hDEAD);
    chk("mem addr", 32'h0000_0100, l_addr);
    chk("mem data", 32'hDEAD_BEEF, l_wd);
    chk("mem be we", 32'h1F, {27'h0, l_be, l_we});
    avchk(HPT_AV_PTR, 32'h0000_0104);
    wr2(HPT_SEL_FIX, 2'h2, 16'h1111, 16'h2222);
    chk("byte mask", 32'h5, {28'h0, l_be});
    chk("masked data", 32'h2222_1111, l_wd);
    avchk(HPT_AV_PTR, 32'h0000_0104);
    $display("test writes done");
    av(1'b1, HPT_AV_BLK0_BASE, 32'h0000_0104);
    av(1'b1, HPT_AV_BLK0_MASK, 32'hFFFF_FFFF);
    k = n_mem;
    wr2(HPT_SEL_FIX, 2'h0, 16'h3333, 16'h4444);
    chk("blocked", k, n_mem);
    av(1'b1, HPT_AV_BLK0_MASK, 32'h0000_0000);
    $display("test blocked done");
    av(1'b1, HPT_AV_CTRL, 32'h0000_0001);
    rd2(HPT_SEL_FIX, 16'h1234, 16'h0104);
    rd2(HPT_SEL_INC, 16'h1234, 16'h0104);
    chk("prefetch", 32'h0000_0108, l_addr);
    chk("prefetch rd", 32'h0, {31'h0, l_we});
    rd2(HPT_SEL_INC, 16'h1234, 16'h0108);
    avchk(HPT_AV_PTR, 32'h0000_010C);
    $display("test reads done");
    wr2(HPT_SEL_CTRL, 2'h0, 16'h0003, 16'h0003);
    chk("core int", 32'h1, {31'h0, cint});
    av(1'b1, HPT_AV_CTRL, 32'h0000_0003);
    chk("core int clr", 32'h0, {31'h0, cint});
    av(1'b1, HPT_AV_CTRL, 32'h0000_0005);
    chk("host int", 32'h0, {31'h0, host_interrupt_n_n});
    wr2(HPT_SEL_CTRL, 2'h0, 16'h0005, 16'h0005);
    chk("host int clr", 32'h1, {31'h0, host_interrupt_n_n});
    avchk(HPT_AV_CTRL, 32'h0000_0009);
    $display("test interrupts done");
    summarize();
  end
endmodule : tb_hpt_host_port
